/* File: bench/dram_model.sv */
// behavioural page-mode dram facing the strobe host
`timescale 1ns/1ps
module dram_model #(
    parameter int ACC_NS = 35
) (
    input wire logic ras_n,
    input wire logic lcs_n,
    input wire logic hcs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [8:0] addr,
    input wire logic host_oe,
    input wire logic [15:0] host_d,
    output logic [15:0] bus
);
    logic [15:0] mem [0:262143];
    logic [17:0] a;
    logic [15:0] dout = 16'h0;
    logic [1:0] lane = 2'h0;
    logic ref_cycle = 1'h0;
    logic ok = 1'h0;
    int n_refresh = 0;
    int n_err = 0;
    realtime t_up = -1e3;
    realtime t_dn = -1e3;
    wire cs_n = lcs_n & hcs_n;
    task automatic put();
        if (!host_oe) n_err++;
        for (int i = 0; i < 2; i++)
            if (lane[i]) mem[a][i*8 +: 8] = host_d[i*8 +: 8];
    endtask
    always @(negedge ras_n) begin
        if ($realtime - t_up < 40) n_err++;
        t_dn = $realtime;
        ref_cycle = !cs_n;
        n_refresh += ref_cycle;
        if (!ref_cycle) a[17:9] = addr;
    end
    always @(posedge ras_n) begin
        if ($realtime - t_dn < 60) n_err++;
        t_up = $realtime;
    end
    always @(negedge cs_n)
        if (!ras_n && !ref_cycle) begin
            a[8:0] = addr;
            lane = ~{hcs_n, lcs_n};
            ok = 1'h0;
            #1;
            if (!we_n)
                put();
            else begin
                dout = mem[a];
                #(ACC_NS - 1);
                ok = 1'h1;
            end
        end
    always @(negedge we_n)
        if (!ras_n && !cs_n && !ref_cycle)
            #1 put();
    // released lanes show the inverse so stale data never looks valid
    always_comb
        for (int i = 0; i < 2; i++)
            bus[i*8 +: 8] = host_oe ? host_d[i*8 +: 8] :
                lane[i] && ok && we_n && !oe_n ? dout[i*8 +: 8] : ~dout[i*8 +: 8];
endmodule

/* File: bench/test_dram_strobe_host.sv */
// self-checking bench for the strobe-interface dram host
`timescale 1ns/1ps
`define CMP(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_dram_strobe_host;
    logic CLK_SYS = 1'h0;
    logic RESET = 1'h1;
    logic REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_RMW = 1'h0, RSP_READY = 1'h0, stall = 1'h0;
    logic [17:0] REQ_ADDR = 18'h0;
    logic [1:0] REQ_BYTE_EN = 2'h0;
    logic [15:0] REQ_WDATA = 16'h0, r, RSP_DATA, DATA_BUS_IN, DATA_BUS_OUT;
    logic REQ_READY, RSP_VALID, INIT_DONE, RAS_N, LOW_BYTE_COL_STROBE_N, HIGH_BYTE_COL_STROBE_N;
    logic WE_N, OE_N, DATA_BUS_OE;
    logic [8:0] MUX_ADDRESS;
    logic [8:0] rows [3] = '{9'h0, 9'h5, 9'h1ff};
    logic [15:0] shadow [logic [17:0]];
    logic [31:0] exp_q [$];
    logic [31:0] ent;
    logic [31:0] seed = 32'h27;
    int n_mismatch = 0, cmp_count = 0, n_ref;
    dram_strobe_host #(.POWERUP_WAIT_CYC(20)) u_dram_strobe_host (.CLK_SYS, .RESET, .REQ_VALID, .REQ_READY,
        .REQ_WRITE, .REQ_RMW, .REQ_ADDR, .REQ_BYTE_EN, .REQ_WDATA, .RSP_VALID, .RSP_READY, .RSP_DATA, .INIT_DONE,
        .RAS_N, .LOW_BYTE_COL_STROBE_N, .HIGH_BYTE_COL_STROBE_N, .WE_N, .OE_N, .MUX_ADDRESS, .DATA_BUS_IN,
        .DATA_BUS_OUT, .DATA_BUS_OE);
    dram_model u_dram_model (.ras_n(RAS_N), .lcs_n(LOW_BYTE_COL_STROBE_N), .hcs_n(HIGH_BYTE_COL_STROBE_N),
        .we_n(WE_N), .oe_n(OE_N), .addr(MUX_ADDRESS), .host_oe(DATA_BUS_OE), .host_d(DATA_BUS_OUT), .bus(DATA_BUS_IN));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // holds the request until ready is seen settled, so the next edge takes it
    task automatic req(input logic w, input logic m, input logic [17:0] a, input logic [1:0] be, input logic [15:0] d);
        logic [15:0] k;
        int n;
        k = {{8{be[1] | ~|be}}, {8{be[0] | ~|be}}};
        n = 0;
        @(posedge CLK_SYS);
        REQ_VALID <= 1'h1;
        REQ_WRITE <= w;
        REQ_RMW <= m;
        REQ_ADDR <= a;
        REQ_BYTE_EN <= be;
        REQ_WDATA <= d;
        do begin
            @(negedge CLK_SYS);
            n++;
        end while (REQ_READY !== 1'h1 && n < 3000);
        if (n >= 3000) `CMP(1'h0, 1'h1, "request never taken")
        @(posedge CLK_SYS);
        REQ_VALID <= 1'h0;
        if (!w || m) exp_q.push_back({k, shadow[a] & k});
        if (w || m) shadow[a] = (shadow[a] & ~k) | (d & k);
    endtask
    task automatic drain();
        for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge CLK_SYS);
        `CMP(exp_q.size(), 0, "responses missing")
    endtask
    always #5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) RSP_READY <= !stall && rnd() % 3 != 0;
    always @(posedge CLK_SYS)
        if (!RESET && RSP_VALID === 1'h1 && RSP_READY) begin
            if (exp_q.size() == 0) `CMP(1'h1, 1'h0, "unexpected read data")
            else begin
                ent = exp_q.pop_front();
                `CMP(RSP_DATA & ent[31:16], ent[15:0], "read data")
            end
        end
    initial begin
        #200us;
        n_mismatch++;
        $display("CHECK FAILED %0t watchdog", $time);
        finish_test();
    end
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RESET <= 1'h0;
        for (int n = 0; n < 500 && INIT_DONE !== 1'h1; n++) @(posedge CLK_SYS);
        `CMP(INIT_DONE, 1'h1, "init done")
        `CMP(u_dram_model.n_refresh >= 8, 1'h1, "wake cycles")
        for (int i = 0; i < 9; i++)
            req(1'h1, 1'h0, {rows[i % 3], rows[i / 3]}, 2'h3, rnd());
        $display("done: fill rows");
        for (int i = 0; i < 16; i++)
            req(i < 4, 1'h0, {rows[1], rows[i % 3]}, 2'(i), rnd());
        drain();
        $display("done: byte lanes in page");
        for (int i = 0; i < 9; i++)
            req(1'h0, 1'h1, {rows[i / 3], rows[i % 3]}, 2'h3, rnd());
        drain();
        $display("done: read-write");
        stall <= 1'h1;
        fork
            begin
                repeat (200) @(posedge CLK_SYS);
                stall <= 1'h0;
            end
        join_none
        for (int i = 0; i < 4; i++)
            req(1'h0, 1'h0, {rows[2], rows[i % 3]}, 2'h3, 16'h0);
        `CMP(stall, 1'h0, "read taken while buffer full")
        drain();
        $display("done: stalled consumer");
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            req(r[0], r[1] & ~r[0], {rows[r[3:2] % 3], rows[r[5:4] % 3]}, r[7:6], rnd());
        end
        drain();
        $display("done: random mix");
        n_ref = u_dram_model.n_refresh;
        repeat (3200) @(posedge CLK_SYS);
        `CMP(u_dram_model.n_refresh - n_ref >= 2, 1'h1, "refresh paced")
        for (int i = 0; i < 9; i++)
            req(1'h0, 1'h0, {rows[i % 3], rows[i / 3]}, 2'h3, 16'h0);
        drain();
        `CMP(u_dram_model.n_err, 0, "strobe timing")
        $display("done: refresh and retention");
        finish_test();
    end
endmodule

/* File: rtl/dram_host_pkg.sv */
// constants and state codes shared by the strobe-interface dram host
package dram_host_pkg;
    localparam int ADDR_W = 18;
    localparam int HALF_W = 9;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int RUN_W = 11;
    localparam int CLK_NS = 10;
    // strobe timing in ns, slowest speed grade
    localparam int RAS_MIN_NS = 60;
    localparam int RAS_MAX_NS = 10000;
    localparam int ROW_PRECHARGE_MIN_NS = 40;
    localparam int COL_PRECHARGE_MIN_NS = 10;
    localparam int CAS_MIN_NS = 10;
    localparam int RCD_NS = 20;
    localparam int RAC_NS = 60;
    localparam int CAC_NS = 15;
    localparam int AA_NS = 30;
    localparam int ACCESS_NS = (AA_NS > CAC_NS ? AA_NS : CAC_NS) > (RAC_NS - RCD_NS) ?
        (AA_NS > CAC_NS ? AA_NS : CAC_NS) : (RAC_NS - RCD_NS);
    localparam int POWERUP_US = 200;
    localparam int REFRESH_INTERVAL_MS = 8;
    localparam int REFRESH_ROWS = 512;
    localparam int WAKE_CYCLES = 8;
    localparam int SYNC_STAGES = 2;
    localparam int PAGE_SLACK_CYC = 32;
    // derived cycle counts: minimums round up, maximums round down
    localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAGE_LIMIT_CYC = RAS_MAX_NS / CLK_NS;
    localparam int ROW_PRE_CYC = (ROW_PRECHARGE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int COL_PRE_CYC = (COL_PRECHARGE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAS_MIN_CYC = (CAS_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCD_CYC = (RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1;
    localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int REFRESH_PERIOD_CYC = (REFRESH_INTERVAL_MS * 1000000) / (REFRESH_ROWS * CLK_NS);

    typedef enum logic [3:0] {
        ST_POWERUP = 4'b0000,
        ST_IDLE = 4'b0001,
        ST_REF_COL = 4'b0010,
        ST_REF_ROW = 4'b0011,
        ST_REF_PRE = 4'b0100,
        ST_ROW = 4'b0101,
        ST_COL = 4'b0110,
        ST_RMW_TURN = 4'b0111,
        ST_RMW_WR = 4'b1000,
        ST_COL_PRE = 4'b1001,
        ST_PAGE = 4'b1010,
        ST_HIDE_CAS = 4'b1011,
        ST_HIDE_RAS_HI = 4'b1100,
        ST_HIDE_RAS_LO = 4'b1101,
        ST_CLOSE = 4'b1110
    } state_e;
endpackage

/* File: rtl/dram_strobe_host.sv */
// host controller driving an asynchronous page-mode dram over its strobe pins
`timescale 1ns/1ps
module dram_strobe_host #(
    parameter int POWERUP_WAIT_CYC = dram_host_pkg::POWERUP_CYC
) (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic REQ_RMW,
    input wire logic [dram_host_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [1:0] REQ_BYTE_EN,
    input wire logic [dram_host_pkg::DATA_W-1:0] REQ_WDATA,
    output logic RSP_VALID,
    input wire logic RSP_READY,
    output logic [dram_host_pkg::DATA_W-1:0] RSP_DATA,
    output logic INIT_DONE,
    output logic RAS_N,
    output logic LOW_BYTE_COL_STROBE_N,
    output logic HIGH_BYTE_COL_STROBE_N,
    output logic WE_N,
    output logic OE_N,
    output logic [dram_host_pkg::HALF_W-1:0] MUX_ADDRESS,
    input wire logic [dram_host_pkg::DATA_W-1:0] DATA_BUS_IN,
    output logic [dram_host_pkg::DATA_W-1:0] DATA_BUS_OUT,
    output logic DATA_BUS_OE
);
    import dram_host_pkg::*;

    state_e state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [3:0] wake_cnt, next_wake_cnt;
    logic init_done, next_init_done;
    logic [ADDR_W-1:0] req_addr, next_req_addr;
    logic [DATA_W-1:0] req_wdata, next_req_wdata;
    logic [1:0] req_be, next_req_be;
    logic req_write, next_req_write;
    logic req_rmw, next_req_rmw;
    logic next_ras_n, next_low_strobe_n, next_high_strobe_n, next_we_n, next_oe_n, next_data_oe;
    logic [HALF_W-1:0] next_addr;
    logic [DATA_W-1:0] next_wdata;
    logic [RUN_W-1:0] ras_run, next_ras_run;
    logic [DATA_W-1:0] data_s1, data_s2;
    logic ready, push, room, ref_due, ref_overdue, ref_done, ref_clear;
    logic same_row, ras_ok, page_old, need_room, at_end;

    //////////////////////////////////////////////////////////////////////
    // helpers
    resp_buffer #(.WIDTH(DATA_W), .DEPTH(2)) u_resp (
        .clk(CLK_SYS),
        .rst(RESET),
        .in_valid(push),
        .in_ready(room),
        .in_data(data_s2),
        .out_valid(RSP_VALID),
        .out_ready(RSP_READY),
        .out_data(RSP_DATA)
    );

    refresh_timer #(.PERIOD_CYC(REFRESH_PERIOD_CYC), .OWED_LIMIT(REFRESH_ROWS)) u_refresh (
        .clk(CLK_SYS),
        .rst(RESET),
        .done(ref_done),
        .clear(ref_clear),
        .due(ref_due),
        .overdue(ref_overdue)
    );

    // read bus comes from off-chip: two flops before any use
    always_ff @(posedge CLK_SYS) begin
        data_s1 <= DATA_BUS_IN;
        data_s2 <= data_s1;
    end

    assign same_row = (REQ_ADDR[ADDR_W-1:HALF_W] == req_addr[ADDR_W-1:HALF_W]);
    assign ras_ok = (ras_run >= RUN_W'(RAS_MIN_CYC - 1));
    // leave room so a started page access never passes the row maximum
    assign page_old = (ras_run >= RUN_W'(PAGE_LIMIT_CYC - PAGE_SLACK_CYC));
    // reads and read-writes hold a slot in the buffer before starting
    assign need_room = !REQ_WRITE || REQ_RMW;
    assign REQ_READY = ready;
    assign INIT_DONE = init_done;

    //////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        next_state = state;
        next_cnt = cnt + 1'b1;
        next_wake_cnt = wake_cnt;
        next_init_done = init_done;
        next_req_addr = req_addr;
        next_req_wdata = req_wdata;
        next_req_be = req_be;
        next_req_write = req_write;
        next_req_rmw = req_rmw;
        ready = 1'b0;
        push = 1'b0;
        ref_done = 1'b0;
        ref_clear = 1'b0;
        at_end = 1'b0;
        unique case (state)
            ST_POWERUP: begin
                if (cnt == CNT_W'(POWERUP_WAIT_CYC - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (ref_overdue && init_done) begin
                    next_init_done = 1'b0;
                    next_wake_cnt = '0;
                    next_state = ST_REF_COL;
                end else if (!init_done || ref_due) begin
                    next_state = ST_REF_COL;
                end else begin
                    ready = !need_room || room;
                    if (REQ_VALID && ready) begin
                        next_state = ST_ROW;
                    end
                end
            end
            ST_REF_COL: begin
                if (cnt == CNT_W'(CAS_MIN_CYC - 1)) begin
                    next_state = ST_REF_ROW;
                end
            end
            ST_REF_ROW: begin
                if (cnt == CNT_W'(RAS_MIN_CYC - 1)) begin
                    ref_done = 1'b1;
                    next_wake_cnt = init_done ? wake_cnt : wake_cnt + 1'b1;
                    next_state = ST_REF_PRE;
                end
            end
            ST_REF_PRE: begin
                if (cnt == CNT_W'(ROW_PRE_CYC - 1)) begin
                    if (!init_done && wake_cnt == 4'(WAKE_CYCLES)) begin
                        next_init_done = 1'b1;
                        ref_clear = 1'b1;
                    end
                    next_state = ST_IDLE;
                end
            end
            ST_ROW: begin
                if (cnt == CNT_W'(RCD_CYC - 1)) begin
                    next_state = ST_COL;
                end
            end
            ST_COL: begin
                if (!req_write || req_rmw) begin
                    if (cnt == CNT_W'(READ_CYC - 1)) begin
                        push = 1'b1;
                        next_state = req_rmw ? ST_RMW_TURN : ST_COL_PRE;
                    end
                end else if (cnt == CNT_W'(CAS_MIN_CYC - 1)) begin
                    next_state = ST_COL_PRE;
                end
            end
            ST_RMW_TURN: begin
                next_state = ST_RMW_WR;
            end
            ST_RMW_WR: begin
                if (cnt == CNT_W'(CAS_MIN_CYC - 1)) begin
                    next_state = ST_COL_PRE;
                end
            end
            ST_COL_PRE: begin
                if (cnt == CNT_W'(COL_PRE_CYC - 1)) begin
                    next_state = ST_PAGE;
                end
            end
            ST_PAGE: begin
                if (ref_due || ref_overdue) begin
                    if (ras_ok) begin
                        next_state = ST_HIDE_CAS;
                    end
                end else if (!page_old && same_row && (!need_room || room)) begin
                    ready = 1'b1;
                    if (REQ_VALID) begin
                        next_state = ST_COL;
                    end
                end else if ((REQ_VALID || page_old) && ras_ok) begin
                    next_state = ST_CLOSE;
                end
            end
            ST_HIDE_CAS: begin
                if (cnt == CNT_W'(CAS_MIN_CYC - 1)) begin
                    next_state = ST_HIDE_RAS_HI;
                end
            end
            ST_HIDE_RAS_HI: begin
                if (cnt == CNT_W'(ROW_PRE_CYC - 1)) begin
                    next_state = ST_HIDE_RAS_LO;
                end
            end
            ST_HIDE_RAS_LO: begin
                if (cnt == CNT_W'(RAS_MIN_CYC - 1)) begin
                    ref_done = 1'b1;
                    next_state = ST_REF_PRE;
                end
            end
            ST_CLOSE: begin
                if (cnt == CNT_W'(ROW_PRE_CYC - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (REQ_VALID && ready) begin
            next_req_addr = REQ_ADDR;
            next_req_wdata = REQ_WDATA;
            next_req_be = (REQ_BYTE_EN == 2'b00) ? 2'b11 : REQ_BYTE_EN;
            next_req_write = REQ_WRITE;
            next_req_rmw = REQ_RMW;
        end
        if (next_state != state) begin
            next_cnt = '0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // pin values follow the state being entered, so pins line up with state
    always_comb begin
        next_ras_n = 1'b1;
        next_low_strobe_n = 1'b1;
        next_high_strobe_n = 1'b1;
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_data_oe = 1'b0;
        next_addr = MUX_ADDRESS;
        next_wdata = DATA_BUS_OUT;
        unique case (next_state)
            ST_REF_COL, ST_HIDE_CAS, ST_HIDE_RAS_HI: begin
                next_ras_n = (next_state != ST_HIDE_CAS);
                next_low_strobe_n = 1'b0;
                next_high_strobe_n = 1'b0;
            end
            ST_REF_ROW, ST_HIDE_RAS_LO: begin
                next_ras_n = 1'b0;
                next_low_strobe_n = 1'b0;
                next_high_strobe_n = 1'b0;
            end
            ST_ROW: begin
                next_ras_n = 1'b0;
                next_addr = next_req_addr[ADDR_W-1:HALF_W];
            end
            ST_COL, ST_RMW_TURN, ST_RMW_WR: begin
                next_ras_n = 1'b0;
                next_addr = next_req_addr[HALF_W-1:0];
                next_low_strobe_n = !next_req_be[0];
                next_high_strobe_n = !next_req_be[1];
                if (next_state == ST_COL) begin
                    next_we_n = !next_req_write || next_req_rmw;
                    next_oe_n = next_req_write && !next_req_rmw;
                    next_data_oe = next_req_write && !next_req_rmw;
                end else begin
                    next_we_n = (next_state == ST_RMW_TURN);
                    next_data_oe = (next_state == ST_RMW_WR);
                end
                next_wdata = next_req_wdata;
            end
            ST_COL_PRE, ST_PAGE: begin
                next_ras_n = 1'b0;
            end
            default: begin
                next_ras_n = 1'b1;
            end
        endcase
        next_ras_run = (next_ras_n != RAS_N) ? '0 :
            (ras_run == '1) ? ras_run : ras_run + 1'b1;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= ST_POWERUP;
            cnt <= '0;
            wake_cnt <= '0;
            init_done <= 1'b0;
            req_addr <= '0;
            req_wdata <= '0;
            req_be <= 2'b11;
            req_write <= 1'b0;
            req_rmw <= 1'b0;
            RAS_N <= 1'b1;
            LOW_BYTE_COL_STROBE_N <= 1'b1;
            HIGH_BYTE_COL_STROBE_N <= 1'b1;
            WE_N <= 1'b1;
            OE_N <= 1'b1;
            DATA_BUS_OE <= 1'b0;
            MUX_ADDRESS <= '0;
            DATA_BUS_OUT <= '0;
            ras_run <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wake_cnt <= next_wake_cnt;
            init_done <= next_init_done;
            req_addr <= next_req_addr;
            req_wdata <= next_req_wdata;
            req_be <= next_req_be;
            req_write <= next_req_write;
            req_rmw <= next_req_rmw;
            RAS_N <= next_ras_n;
            LOW_BYTE_COL_STROBE_N <= next_low_strobe_n;
            HIGH_BYTE_COL_STROBE_N <= next_high_strobe_n;
            WE_N <= next_we_n;
            OE_N <= next_oe_n;
            DATA_BUS_OE <= next_data_oe;
            MUX_ADDRESS <= next_addr;
            DATA_BUS_OUT <= next_wdata;
            ras_run <= next_ras_run;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // checks
    property p_ras_width;
        @(posedge CLK_SYS) disable iff (RESET) $rose(RAS_N) |-> $past(ras_run) >= RUN_W'(RAS_MIN_CYC - 1);
    endproperty
    a_ras_width: assert property (p_ras_width) else $error("row strobe low too short");

    property p_row_pre;
        @(posedge CLK_SYS) disable iff (RESET) $fell(RAS_N) |-> $past(ras_run) >= RUN_W'(ROW_PRE_CYC - 1);
    endproperty
    a_row_pre: assert property (p_row_pre) else $error("row precharge too short");

    property p_read_we;
        @(posedge CLK_SYS) disable iff (RESET) !OE_N |-> WE_N && !DATA_BUS_OE;
    endproperty
    a_read_we: assert property (p_read_we) else $error("output enable low while writing");

    property p_write_data;
        @(posedge CLK_SYS) disable iff (RESET)
            (!WE_N && !(LOW_BYTE_COL_STROBE_N && HIGH_BYTE_COL_STROBE_N)) |-> DATA_BUS_OE && OE_N;
    endproperty
    a_write_data: assert property (p_write_data) else $error("write without driven data");

    property p_col_hold;
        @(posedge CLK_SYS) disable iff (RESET) (state == ST_COL && $past(state) == ST_COL) |-> $stable(MUX_ADDRESS);
    endproperty
    a_col_hold: assert property (p_col_hold) else $error("column address moved during access");

    property p_row_addr;
        @(posedge CLK_SYS) disable iff (RESET)
            ($fell(RAS_N) && LOW_BYTE_COL_STROBE_N && HIGH_BYTE_COL_STROBE_N)
            |-> MUX_ADDRESS == req_addr[ADDR_W-1:HALF_W];
    endproperty
    a_row_addr: assert property (p_row_addr) else $error("wrong row half at row strobe");

    property p_ref_quiet;
        @(posedge CLK_SYS) disable iff (RESET)
            ($fell(RAS_N) && !(LOW_BYTE_COL_STROBE_N && HIGH_BYTE_COL_STROBE_N))
            |-> (OE_N && WE_N && !DATA_BUS_OE) [*2];
    endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("data access in refresh");

    property p_init;
        @(posedge CLK_SYS) disable iff (RESET) $rose(INIT_DONE) |-> wake_cnt == 4'(WAKE_CYCLES) && $past(ref_clear);
    endproperty
    a_init: assert property (p_init) else $error("ready before eight wake cycles");

    property p_refresh;
        @(posedge CLK_SYS) disable iff (RESET) (INIT_DONE && $rose(ref_due)) |-> ##[1:300] ref_done;
    endproperty
    a_refresh: assert property (p_refresh) else $error("refresh not served in time");

    property p_page;
        @(posedge CLK_SYS) disable iff (RESET) (state == ST_COL_PRE) |=> !RAS_N && state != ST_ROW;
    endproperty
    a_page: assert property (p_page) else $error("row closed inside page");
endmodule

/* File: rtl/refresh_timer.sv */
// refresh pacing: one refresh owed per period, overdue after a full backlog
`timescale 1ns/1ps
module refresh_timer #(
    parameter int PERIOD_CYC = 1562,
    parameter int OWED_LIMIT = 512
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic done,
    input wire logic clear,
    output logic due,
    output logic overdue
);
    localparam int TICK_W = $clog2(PERIOD_CYC + 1);
    localparam int OWED_W = $clog2(OWED_LIMIT + 1);
    logic [TICK_W-1:0] tick, next_tick;
    logic [OWED_W-1:0] owed, next_owed;
    logic wrap;

    assign wrap = (tick == TICK_W'(PERIOD_CYC - 1));
    assign due = (owed != '0);
    // a full interval's worth owed means the retention limit has been passed
    assign overdue = (owed == OWED_W'(OWED_LIMIT));

    always_comb begin
        next_tick = wrap ? '0 : tick + 1'b1;
        next_owed = owed;
        if (clear) begin
            // a tick landing on the clear still owes a refresh
            next_owed = wrap ? OWED_W'(1) : '0;
        end else if (wrap && !done && !overdue) begin
            next_owed = owed + 1'b1;
        end else if (!wrap && done && due) begin
            next_owed = owed - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick <= '0;
            owed <= '0;
        end else begin
            tick <= next_tick;
            owed <= next_owed;
        end
    end
endmodule

/* File: rtl/resp_buffer.sv */
// two-entry buffer for read data with valid/ready on both sides
`timescale 1ns/1ps
module resp_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PTR_W:0] count, next_count;
    logic push, pop;

    assign in_ready = (count != (PTR_W+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_mem[wr_ptr] = in_data;
            next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge clk) begin
        mem <= next_mem;
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule
